//--- rtl/slice_map.svh
`ifndef SLICE_MAP_SVH
`define SLICE_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SLICE_CONFIG_ADDR     4'h0
`define SLICE_LOWER_LUT_ADDR  4'h4
`define SLICE_UPPER_LUT_ADDR  4'h8
`define SLICE_STATUS_ADDR     4'hc

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define CFG_LOWER_LATCH       0
`define CFG_UPPER_LATCH       1
`define CFG_LOWER_D_BYPASS    2
`define CFG_UPPER_D_BYPASS    3
`define CFG_FORCE_ASYNC       4
`define CFG_FORCE_HIGH        5
`define CFG_INV_SHARED        6
`define CFG_INV_OPPOSITE      7
`define CFG_INV_ENABLE        8
`define CFG_INV_GATE          9
`define CFG_LOWER_SHIFT       10
`define CFG_UPPER_SHIFT       11
`define CFG_CASCADE_INTRA     12
`define CFG_LOWER_PROPAGATE   13
`define CFG_UPPER_PROPAGATE   14
`define CFG_INIT_BYPASS       15
`define CFG_LOWER_GEN_BYPASS  16
`define CFG_UPPER_GEN_BYPASS  17
`define CFG_LOWER_OUT_SUM     18
`define CFG_UPPER_OUT_SUM     19
`define CFG_UPPER_DIN_CHAIN   20
`define CFG_ENABLE_UNUSED     21
`define CFG_WIDTH             22

`define CFG_RESET             22'h000000
`define LUT_RESET             16'h0000
`define SHIFT_DEPTH           16

`endif

//--- rtl/slice_pkg.sv
package slice_pkg;

    typedef struct packed {
        logic [3:0] lower_lut_in;
        logic [3:0] upper_lut_in;
        logic       lower_bypass_in;
        logic       upper_bypass_in;
        logic       carry_in;
        logic       shared_force_input;
        logic       opposite_force_input;
        logic       clock_enable;
        logic       gate;
        logic       shift_chain_in;
    } fabric_in_t;

    typedef struct packed {
        logic carry_out;
        logic lower_comb;
        logic upper_comb;
        logic lower_q;
        logic upper_q;
        logic final_stage_cascade_out;
        logic shift_chain_out;
    } fabric_out_t;

    typedef struct packed {
        logic sync_low;
        logic sync_high;
        logic async_low;
        logic async_high;
    } force_t;

endpackage

//--- rtl/storage_element.sv
`timescale 1ns/10ps
module storage_element (
    // clock and reset
    input  wire logic            clock,
    input  wire logic            rst_b,
    // configuration
    input  wire logic            latch_mode,
    // shared controls and data
    input  wire logic            enable,
    input  wire logic            gate,
    input  wire slice_pkg::force_t force_in,
    input  wire logic            d,
    // output
    output logic                 q
);
    logic held;
    logic any_low;
    logic any_high;
    logic transparent;

    // ----------------------------------------------------------------
    // force decode: low always wins over high
    // ----------------------------------------------------------------
    assign any_low     = force_in.sync_low | force_in.async_low;
    assign any_high    = force_in.sync_high | force_in.async_high;
    assign transparent = latch_mode & gate & enable;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            held <= 1'b0;
        end else if (any_low) begin
            held <= 1'b0;
        end else if (any_high) begin
            held <= 1'b1;
        end else if (!latch_mode && enable) begin
            held <= d;
        end else if (transparent) begin
            held <= d;
        end
    end

    // ----------------------------------------------------------------
    // output: latch and async forces act at once
    // ----------------------------------------------------------------
    always_comb begin
        q = held;
        if (latch_mode || force_in.async_low || force_in.async_high) begin
            if (force_in.async_low || (latch_mode && force_in.sync_low)) begin
                q = 1'b0;
            end else if (force_in.async_high || (latch_mode && force_in.sync_high)) begin
                q = 1'b1;
            end else if (transparent) begin
                q = d;
            end
        end
    end
endmodule

//--- rtl/lut_shift_register.sv
`timescale 1ns/10ps
`include "slice_map.svh"
module lut_shift_register (
    // clock
    input  wire logic        clock,
    // configuration
    input  wire logic        shift_mode,
    input  wire logic [15:0] truth,
    // data
    input  wire logic        enable,
    input  wire logic        din,
    input  wire logic [3:0]  addr,
    output logic             dout,
    output logic             final_stage
);
    logic [`SHIFT_DEPTH-1:0] stage;

    // ----------------------------------------------------------------
    // contents change only by shifting, no reset path
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (shift_mode && enable) begin
            stage <= {stage[`SHIFT_DEPTH-2:0], din};
        end
    end

    assign dout        = shift_mode ? stage[addr] : truth[addr];
    assign final_stage = stage[`SHIFT_DEPTH-1];
endmodule

//--- rtl/slice_carry_storage_shift.sv
// Behaviour
// - each half: lut half-sum, carry mux, xor with incoming carry; two bits per slice
// - lower carry mux passes chain carry on select 1, generated carry on 0
// - two-input and gate per half feeds carry-generate of its carry mux
// - each storage element works as d flip-flop or transparent latch
// - element data selects combinational output or bypass input of its half
// - flip-flop loads on rising edge when no force active and enable high
// - latch follows data while gate and enable high, holds otherwise
// - set drives flip-flop high at next edge, latch high at once
// - synchronous reset beats synchronous set, output low
// - asynchronous clear beats asynchronous preset, output low
// - each control has selectable polarity, active high by default; clock has no polarity select here, rising edge only
// - opposite force applies inverse value with same sync or async kind
// - reset, set, enable and clock shared by both elements
// - each lut can be a 16-stage shift register delaying 1 to 16 cycles
// - upper table cascades into lower and through chain lines to slice below
// - final stage on cascade output, addressed stage on normal output
// - shift on rising edge only with enable high, else outputs hold
// - shift contents have no reset or preload path
// - both tables share clock and enable; unused enable held active
// - following flip-flop may register addressed output, one extra cycle
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "slice_map.svh"
module slice_carry_storage_shift (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // avalon-mm slave
    input  wire logic [3:0]             address,
    input  wire logic                   read,
    input  wire logic                   write,
    input  wire logic [31:0]            writedata,
    output logic      [31:0]            readdata,
    output logic                        waitrequest,
    // fabric side
    input  wire slice_pkg::fabric_in_t  fabric_in,
    output slice_pkg::fabric_out_t      fabric_out
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    // bus and configuration
    logic [`CFG_WIDTH-1:0] config_reg;
    logic [15:0]           lower_truth;
    logic [15:0]           upper_truth;
    logic                  ack;
    logic                  write_take;
    logic                  read_take;

    // look-up tables
    logic                  lower_lut_out;
    logic                  upper_lut_out;
    logic                  upper_final;
    logic                  lower_final;
    logic                  upper_din;
    logic                  lower_din;

    // carry chain and arithmetic
    logic                  chain_carry_init;
    logic                  lower_product_gate;
    logic                  upper_product_gate;
    logic                  lower_carry_select;
    logic                  upper_carry_select;
    logic                  lower_gen;
    logic                  upper_gen;
    logic                  lower_carry_mux;
    logic                  upper_carry_mux;
    logic                  lower_sum_gate;
    logic                  upper_sum_gate;
    logic                  lower_comb;
    logic                  upper_comb;

    // storage controls and readback
    logic                  shared_act;
    logic                  opposite_act;
    logic                  enable_act;
    logic                  gate_act;
    slice_pkg::force_t     force_bus;
    logic                  lower_d;
    logic                  upper_d;
    logic                  lower_q;
    logic                  upper_q;
    logic [6:0]            status_word;
    logic [31:0]           next_readdata;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic polarity(input logic raw, input logic invert);
        polarity = raw ^ invert;
    endfunction

    function automatic logic carry_mux(input logic sel, input logic prop, input logic gen);
        carry_mux = sel ? prop : gen;
    endfunction

    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] target);
        reg_hit = (addr == target);
    endfunction

    // ----------------------------------------------------------------
    // bus handshake: one wait state per access
    // ----------------------------------------------------------------
    // read taken in the first cycle, write taken in the second; both answered in the second
    assign waitrequest = (read | write) & ~ack;
    assign write_take  = write & ack;
    assign read_take   = read & ~ack;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else if (ack) begin
            ack <= 1'b0;
        end else begin
            ack <= read | write;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // configuration word
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            config_reg <= `CFG_RESET;
        end else if (write_take && reg_hit(address, `SLICE_CONFIG_ADDR)) begin
            config_reg <= writedata[`CFG_WIDTH-1:0];
        end
    end

    // lower truth table
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lower_truth <= `LUT_RESET;
        end else if (write_take && reg_hit(address, `SLICE_LOWER_LUT_ADDR)) begin
            lower_truth <= writedata[15:0];
        end
    end

    // upper truth table
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            upper_truth <= `LUT_RESET;
        end else if (write_take && reg_hit(address, `SLICE_UPPER_LUT_ADDR)) begin
            upper_truth <= writedata[15:0];
        end
    end

    // ----------------------------------------------------------------
    // read mux, unmapped addresses read zero
    // ----------------------------------------------------------------
    // live slice state for software
    assign status_word = {lower_final, upper_final, upper_q, lower_q,
                          upper_comb, lower_comb, upper_carry_mux};

    always_comb begin
        next_readdata = 32'h00000000;
        case (address)
            `SLICE_CONFIG_ADDR: begin
                next_readdata[`CFG_WIDTH-1:0] = config_reg;
            end
            `SLICE_LOWER_LUT_ADDR: begin
                next_readdata[15:0] = lower_truth;
            end
            `SLICE_UPPER_LUT_ADDR: begin
                next_readdata[15:0] = upper_truth;
            end
            `SLICE_STATUS_ADDR: begin
                next_readdata[6:0] = status_word;
            end
            default: begin
                next_readdata = 32'h00000000;
            end
        endcase
    end

    // loaded in the wait state, stands in the answer cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h00000000;
        end else if (read_take) begin
            readdata <= next_readdata;
        end
    end

    // ----------------------------------------------------------------
    // shared controls with selectable polarity
    // ----------------------------------------------------------------
    // force inputs
    assign shared_act   = polarity(fabric_in.shared_force_input,
                                   config_reg[`CFG_INV_SHARED]);
    assign opposite_act = polarity(fabric_in.opposite_force_input,
                                   config_reg[`CFG_INV_OPPOSITE]);

    // enable and gate
    assign enable_act   = config_reg[`CFG_ENABLE_UNUSED] |
                          polarity(fabric_in.clock_enable,
                                   config_reg[`CFG_INV_ENABLE]);
    assign gate_act     = polarity(fabric_in.gate, config_reg[`CFG_INV_GATE]);

    // shared input forces the chosen value, opposite input the other one
    always_comb begin
        force_bus = '0;
        case ({config_reg[`CFG_FORCE_ASYNC], config_reg[`CFG_FORCE_HIGH]})
            2'b00: begin
                force_bus.sync_low   = shared_act;
                force_bus.sync_high  = opposite_act;
            end
            2'b01: begin
                force_bus.sync_high  = shared_act;
                force_bus.sync_low   = opposite_act;
            end
            2'b10: begin
                force_bus.async_low  = shared_act;
                force_bus.async_high = opposite_act;
            end
            2'b11: begin
                force_bus.async_high = shared_act;
                force_bus.async_low  = opposite_act;
            end
            default: begin
                force_bus = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // look-up tables and shift registers
    // ----------------------------------------------------------------
    // shift inputs of both tables
    assign upper_din = config_reg[`CFG_UPPER_DIN_CHAIN] ? fabric_in.shift_chain_in
                                                        : fabric_in.upper_bypass_in;
    assign lower_din = config_reg[`CFG_CASCADE_INTRA] ? upper_final
                                                      : fabric_in.lower_bypass_in;

    // upper table may take the chain input
    lut_shift_register upper_lookup_table (
        .clock       (clock),
        .shift_mode  (config_reg[`CFG_UPPER_SHIFT]),
        .truth       (upper_truth),
        .enable      (enable_act),
        .din         (upper_din),
        .addr        (fabric_in.upper_lut_in),
        .dout        (upper_lut_out),
        .final_stage (upper_final)
    );

    // lower table may follow the upper final stage
    lut_shift_register lower_lookup_table (
        .clock       (clock),
        .shift_mode  (config_reg[`CFG_LOWER_SHIFT]),
        .truth       (lower_truth),
        .enable      (enable_act),
        .din         (lower_din),
        .addr        (fabric_in.lower_lut_in),
        .dout        (lower_lut_out),
        .final_stage (lower_final)
    );

    // ----------------------------------------------------------------
    // carry chain and arithmetic gates
    // ----------------------------------------------------------------
    // chain entry: carry input or bypass
    assign chain_carry_init   = config_reg[`CFG_INIT_BYPASS] ? fabric_in.lower_bypass_in
                                                             : fabric_in.carry_in;

    // partial products feed carry generate
    assign lower_product_gate = fabric_in.lower_lut_in[0] & fabric_in.lower_lut_in[1];
    assign upper_product_gate = fabric_in.upper_lut_in[0] & fabric_in.upper_lut_in[1];
    assign lower_gen          = config_reg[`CFG_LOWER_GEN_BYPASS] ? fabric_in.lower_bypass_in
                                                                  : lower_product_gate;
    assign upper_gen          = config_reg[`CFG_UPPER_GEN_BYPASS] ? fabric_in.upper_bypass_in
                                                                  : upper_product_gate;

    // propagate while the half-sum is high
    assign lower_carry_select = config_reg[`CFG_LOWER_PROPAGATE] | lower_lut_out;
    assign upper_carry_select = config_reg[`CFG_UPPER_PROPAGATE] | upper_lut_out;
    assign lower_carry_mux    = carry_mux(lower_carry_select, chain_carry_init,
                                          lower_gen);
    assign upper_carry_mux    = carry_mux(upper_carry_select, lower_carry_mux,
                                          upper_gen);

    // sum gates
    assign lower_sum_gate     = lower_lut_out ^ chain_carry_init;
    assign upper_sum_gate     = upper_lut_out ^ lower_carry_mux;

    // combinational output per half
    assign lower_comb = config_reg[`CFG_LOWER_OUT_SUM] ? lower_sum_gate : lower_lut_out;
    assign upper_comb = config_reg[`CFG_UPPER_OUT_SUM] ? upper_sum_gate : upper_lut_out;

    // ----------------------------------------------------------------
    // storage elements
    // ----------------------------------------------------------------
    // element data: combinational output or bypass
    assign lower_d = config_reg[`CFG_LOWER_D_BYPASS] ? fabric_in.lower_bypass_in
                                                     : lower_comb;
    assign upper_d = config_reg[`CFG_UPPER_D_BYPASS] ? fabric_in.upper_bypass_in
                                                     : upper_comb;

    // both elements share enable, gate and forces
    storage_element lower_storage_element (
        .clock      (clock),
        .rst_b      (rst_b),
        .latch_mode (config_reg[`CFG_LOWER_LATCH]),
        .enable     (enable_act),
        .gate       (gate_act),
        .force_in   (force_bus),
        .d          (lower_d),
        .q          (lower_q)
    );

    storage_element upper_storage_element (
        .clock      (clock),
        .rst_b      (rst_b),
        .latch_mode (config_reg[`CFG_UPPER_LATCH]),
        .enable     (enable_act),
        .gate       (gate_act),
        .force_in   (force_bus),
        .d          (upper_d),
        .q          (upper_q)
    );

    // ----------------------------------------------------------------
    // fabric outputs
    // ----------------------------------------------------------------
    assign fabric_out.carry_out               = upper_carry_mux;
    assign fabric_out.lower_comb              = lower_comb;
    assign fabric_out.upper_comb              = upper_comb;

    // registered or latched
    assign fabric_out.lower_q                 = lower_q;
    assign fabric_out.upper_q                 = upper_q;

    // shift cascade
    assign fabric_out.final_stage_cascade_out = upper_final;
    assign fabric_out.shift_chain_out         = lower_final;

endmodule

//--- sim/fabric_neighbour.sv
`timescale 1ns/10ps
module fabric_neighbour (
    // stimulus from the bench
    input  wire slice_pkg::fabric_in_t cmd,
    // drive into the slice
    output slice_pkg::fabric_in_t      fabric_in
);
    assign fabric_in = cmd;
endmodule

//--- sim/slice_monitor.sv
`timescale 1ns/10ps
module slice_monitor (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   rst_b,
    // avalon-mm slave
    input wire logic [3:0]             address,
    input wire logic                   read,
    input wire logic                   write,
    input wire logic [31:0]            writedata,
    input wire logic [31:0]            readdata,
    input wire logic                   waitrequest,
    // fabric side
    input wire slice_pkg::fabric_in_t  fabric_in,
    input wire slice_pkg::fabric_out_t fabric_out
);
    slice_pkg::fabric_in_t  fi;
    slice_pkg::fabric_out_t fo;
    logic [21:0]            cfg;
    logic                   wr_done;
    assign fi = fabric_in;
    assign fo = fabric_out;
    assign wr_done = write && !waitrequest;
    // ----
    // config shadow
    // ----
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b)
            cfg <= 22'h000000;
        else if (wr_done && address == 4'h0)
            cfg <= writedata[21:0];
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence bus_wait; (read || write) && waitrequest; endsequence
    sequence bus_answer; (read || write) && !waitrequest; endsequence
    sequence ff_idle; cfg == 22'h00002c && !wr_done; endsequence
    a_one_wait: assert property (bus_wait |=> bus_answer) else $error("wait state count");
    a_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0
        |-> readdata == 32'h0) else $error("unmapped read not zero");
    a_adder_sum: assert property (cfg == 22'h0c0000 |-> {fo.carry_out, fo.upper_comb,
        fo.lower_comb} == {1'b0, fi.upper_lut_in[0], fi.lower_lut_in[0]}
        + {1'b0, fi.upper_lut_in[1], fi.lower_lut_in[1]} + fi.carry_in) else $error("sum");
    a_ff_load: assert property (ff_idle ##0 (fi.clock_enable && !fi.shared_force_input
        && !fi.opposite_force_input) |=> fo.lower_q == $past(fi.lower_bypass_in)
        && fo.upper_q == $past(fi.upper_bypass_in)) else $error("flop load");
    a_sync_low_wins: assert property (ff_idle ##0 fi.opposite_force_input
        |=> !fo.lower_q && !fo.upper_q) else $error("sync low force");
    a_async_clear: assert property (cfg == 22'h00003c && fi.opposite_force_input
        |-> !fo.lower_q && !fo.upper_q) else $error("async clear");
    a_shift_oldest: assert property (cfg == 22'h001c00 && fi.upper_lut_in == 4'hf
        |-> fo.upper_comb == fo.final_stage_cascade_out) else $error("oldest stage");
    a_shift_hold: assert property (cfg == 22'h001c00 && !fi.clock_enable
        |=> $stable(fo.final_stage_cascade_out) && $stable(fo.shift_chain_out))
        else $error("shift while disabled");
endmodule

bind slice_carry_storage_shift slice_monitor i_mon (.clock, .rst_b, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .fabric_in, .fabric_out);

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic                   clock;
    logic                   rst_b;
    logic [3:0]             address;
    logic                   read;
    logic                   write;
    logic [31:0]            writedata;
    logic [31:0]            readdata;
    logic                   waitrequest;
    slice_pkg::fabric_in_t  cmd;
    slice_pkg::fabric_in_t  fabric_in;
    slice_pkg::fabric_out_t fo;
    logic [1:0]             q;
    logic [31:0]            rd;
    logic [31:0]            pat = 32'h8e3d51a7;
    int                     err_count = 0;
    int                     checked = 0;
    assign q = {fo.lower_q, fo.upper_q};

    slice_carry_storage_shift i_dut (.clock, .rst_b, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .fabric_in, .fabric_out(fo));
    fabric_neighbour i_far (.cmd, .fabric_in);

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= wd;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic cfg(input logic [21:0] v);
        bus(1'b1, 4'h0, {10'h000, v});
    endtask
    // bits: enable, gate, shared, opposite, lower bypass, upper bypass
    task automatic drv(input logic [5:0] v);
        {cmd.clock_enable, cmd.gate, cmd.shared_force_input, cmd.opposite_force_input,
            cmd.lower_bypass_in, cmd.upper_bypass_in} <= v;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        bus(1'b0, 4'h8, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 4'h0, 32'hffffffff);
        bus(1'b1, 4'h6, 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        chk(rd, 32'h003fffff);
        bus(1'b0, 4'h6, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_adder();
        bus(1'b1, 4'h4, 32'h00006666);
        bus(1'b1, 4'h8, 32'h00006666);
        cfg(22'h0c0000);
        for (int v = 0; v < 32; v++) begin
            cmd.lower_lut_in <= {2'b00, v[1], v[0]};
            cmd.upper_lut_in <= {2'b00, v[3], v[2]};
            cmd.carry_in <= v[4];
            @(posedge clock);
            chk({fo.carry_out, fo.upper_comb, fo.lower_comb},
                {1'b0, v[2], v[0]} + {1'b0, v[3], v[1]} + v[4]);
        end
    endtask
    task automatic t_flop();
        drv(6'b100010);
        cfg(22'h00002c);
        tick(2);
        chk(q, 2'b10);
        drv(6'b000001);
        tick(2);
        chk(q, 2'b10);
        drv(6'b001001);
        tick(2);
        chk(q, 2'b11);
        drv(6'b001101);
        tick(2);
        chk(q, 2'b00);
        drv(6'b000010);
        cfg(22'h00012c);
        tick(2);
        chk(q, 2'b10);
        drv(6'b100011);
        cfg(22'h00003c);
        drv(6'b100100);
        tick(1);
        chk(q, 2'b00);
        drv(6'b101100);
        tick(1);
        chk(q, 2'b00);
        drv(6'b101000);
        tick(1);
        chk(q, 2'b11);
        bus(1'b0, 4'hc, 32'h0);
        chk(rd & 32'h0000001f, 32'h00000019);
    endtask
    task automatic t_latch();
        drv(6'b110010);
        cfg(22'h00000f);
        drv(6'b110001);
        tick(1);
        chk(q, 2'b01);
        drv(6'b100010);
        tick(1);
        chk(q, 2'b01);
        drv(6'b010010);
        tick(1);
        chk(q, 2'b01);
        drv(6'b010110);
        tick(1);
        chk(q, 2'b11);
    endtask
    task automatic t_shift();
        cmd.lower_lut_in <= 4'h0;
        cmd.upper_lut_in <= 4'h0;
        drv(6'b100000);
        cfg(22'h001c00);
        for (int i = 0; i < 32; i++) begin
            cmd.upper_bypass_in <= pat[i];
            @(posedge clock);
            if (i > 0)
                chk(fo.upper_comb, pat[i - 1]);
        end
        for (int k = 0; k < 16; k++) begin
            cmd.clock_enable <= 1'b0;
            cmd.upper_lut_in <= k[3:0];
            cmd.lower_lut_in <= k[3:0];
            @(posedge clock);
            chk(fo.upper_comb, pat[31 - k]);
            chk(fo.lower_comb, pat[15 - k]);
            chk({fo.final_stage_cascade_out, fo.shift_chain_out}, {pat[16], pat[0]});
        end
        cmd.upper_lut_in <= 4'h3;
        cmd.clock_enable <= 1'b1;
        cmd.upper_bypass_in <= 1'b1;
        @(posedge clock);
        cmd.clock_enable <= 1'b0;
        @(posedge clock);
        chk({fo.upper_q, fo.upper_comb}, {pat[28], pat[29]});
        cmd.upper_lut_in <= 4'h0;
        cmd.upper_bypass_in <= 1'b0;
        cfg(22'h201c00);
        tick(2);
        chk(fo.upper_comb, 1'b0);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        rst_b = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        cmd = '0;
        tick(3);
        rst_b <= 1'b1;
        t_regs();
        t_adder();
        t_flop();
        t_latch();
        t_shift();
        results();
    end
    initial begin
        tick(5000);
        err_count++;
        results();
    end
endmodule
